// *** design/bar_defs.svh ***
`ifndef BAR_DEFS_SVH
`define BAR_DEFS_SVH

// register indices as printed; byte address is four times the index
`define BAR_RANGE_LOW_IDX 7'h04
`define BAR_RANGE_HIGH_IDX 7'h05
`define BAR_AXI_ADDR_W 8
`define BAR_RANGE_RESET 9'h0FF
`define BAR_ADDR_FIELD_MSB 15
`define BAR_ADDR_FIELD_LSB 9
`define BAR_RSVD_BIT 8
`define BAR_CH0_LSB 0
`define BAR_CH1_LSB 2
`define BAR_CH2_LSB 4
`define BAR_CH3_LSB 6
`define BAR_RESP_OKAY 2'h0
`define BAR_RESP_SLVERR 2'h2

`endif

// *** design/bar_pkg.sv ***
package bar_pkg;

    typedef enum logic [1:0] {
        BAR_RANGE_10V_LO = 2'b00,
        BAR_RANGE_2P5V = 2'b01,
        BAR_RANGE_5V = 2'b10,
        BAR_RANGE_10V_HI = 2'b11
    } bar_range_e;

    typedef enum logic [1:0] {
        BAR_SEL_NONE = 2'b00,
        BAR_SEL_LOW = 2'b01,
        BAR_SEL_HIGH = 2'b10
    } bar_sel_e;

    typedef enum logic [1:0] {
        BAR_WS_COLLECT = 2'b00,
        BAR_WS_COMMIT = 2'b01,
        BAR_WS_RESP = 2'b10
    } bar_wr_state_e;

    typedef logic [8:0] bar_range_word_t;

endpackage

// *** design/bar_range_decode.sv ***
`timescale 1ns/100ps
module bar_range_decode
    import bar_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [1:0] code_in,
    output logic sel_10v_out,
    output logic sel_5v_out,
    output logic sel_2p5v_out
);

    // both 00 and 11 fall back to the widest range, so no code is illegal
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            sel_10v_out <= 1'b1;
            sel_5v_out <= 1'b0;
            sel_2p5v_out <= 1'b0;
        end else begin
            sel_10v_out <= (code_in == BAR_RANGE_10V_LO) || (code_in == BAR_RANGE_10V_HI);
            sel_5v_out <= (code_in == BAR_RANGE_5V);
            sel_2p5v_out <= (code_in == BAR_RANGE_2P5V);
        end
    end

endmodule // bar_range_decode

// *** design/bar_range_regs.sv ***
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "bar_defs.svh"
module bar_range_regs
    import bar_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [`BAR_AXI_ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic [2:0] s_axi_awprot_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [`BAR_AXI_ADDR_W-1:0] s_axi_araddr_in,
    input wire logic [2:0] s_axi_arprot_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [1:0] bank_a_channel_0_range_out,
    output logic [1:0] bank_a_channel_1_range_out,
    output logic [1:0] bank_a_channel_2_range_out,
    output logic [1:0] bank_a_channel_3_range_out,
    output logic [1:0] bank_a_channel_4_range_out,
    output logic [1:0] bank_a_channel_5_range_out,
    output logic [1:0] bank_a_channel_6_range_out,
    output logic [1:0] bank_a_channel_7_range_out,
    output logic [7:0] range_10v_sel_out,
    output logic [7:0] range_5v_sel_out,
    output logic [7:0] range_2p5v_sel_out,
    output logic [7:0] range_changed_out
);

    // register storage: bit 8 reserved, bits 7:0 four range fields
    bar_range_word_t range_low_reg;
    bar_range_word_t range_high_reg;
    bar_range_word_t range_low_next;
    bar_range_word_t range_high_next;

    bar_wr_state_e wr_state_reg;
    logic aw_have_reg;
    logic w_have_reg;
    logic [`BAR_AXI_ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic aw_take;
    logic w_take;
    logic aw_have_next;
    logic w_have_next;
    logic bvalid_next;
    logic ar_take;
    logic rvalid_next;
    bar_sel_e wr_sel;
    bar_sel_e rd_sel;
    logic [15:0] chan_flat;

    // byte address of a register from its printed index
    function automatic logic [`BAR_AXI_ADDR_W-1:0] byte_addr(input logic [6:0] idx);
        byte_addr = {idx[5:0], 2'b00};
    endfunction

    function automatic bar_sel_e decode_addr(input logic [`BAR_AXI_ADDR_W-1:0] addr);
        if (addr == byte_addr(`BAR_RANGE_LOW_IDX)) begin
            decode_addr = BAR_SEL_LOW;
        end else if (addr == byte_addr(`BAR_RANGE_HIGH_IDX)) begin
            decode_addr = BAR_SEL_HIGH;
        end else begin
            decode_addr = BAR_SEL_NONE;
        end
    endfunction

    // read word: own index on top, stored bits below, upper half zero
    function automatic logic [31:0] read_word(input logic [6:0] idx, input bar_range_word_t stored);
        read_word = {16'h0000, idx, stored};
    endfunction

    // only the low two lanes hold stored bits; index bits 15:9 are fixed
    function automatic bar_range_word_t merge_write(input bar_range_word_t old, input logic [31:0] data,
                                                    input logic [3:0] strb);
        bar_range_word_t res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[`BAR_RSVD_BIT] = data[`BAR_RSVD_BIT];
        end
        merge_write = res;
    endfunction

    assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
    assign w_take = s_axi_wvalid_in && s_axi_wready_out;
    assign ar_take = s_axi_arvalid_in && s_axi_arready_out;
    assign wr_sel = decode_addr(aw_addr_reg);
    assign rd_sel = decode_addr(s_axi_araddr_in);

    // write address and data may come in either order; each is held until the other arrives
    always_comb begin
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        bvalid_next = s_axi_bvalid_out;
        if (aw_take) begin
            aw_have_next = 1'b1;
        end
        if (w_take) begin
            w_have_next = 1'b1;
        end
        if (wr_state_reg == BAR_WS_COMMIT) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
        end
        if (s_axi_bvalid_out && s_axi_bready_in) begin
            bvalid_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            wr_state_reg <= BAR_WS_COLLECT;
        end else begin
            case (wr_state_reg)
                BAR_WS_COLLECT: begin
                    if (aw_have_next && w_have_next) begin
                        wr_state_reg <= BAR_WS_COMMIT;
                    end
                end
                BAR_WS_COMMIT: begin
                    wr_state_reg <= BAR_WS_RESP;
                end
                BAR_WS_RESP: begin
                    if (s_axi_bready_in) begin
                        wr_state_reg <= BAR_WS_COLLECT;
                    end
                end
                default: begin
                    wr_state_reg <= BAR_WS_COLLECT;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            aw_have_reg <= 1'b0;
        end else begin
            aw_have_reg <= aw_have_next;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            w_have_reg <= 1'b0;
        end else begin
            w_have_reg <= w_have_next;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            s_axi_bvalid_out <= 1'b0;
        end else begin
            s_axi_bvalid_out <= bvalid_next;
        end
    end

    // readies close once a beat is held and stay closed through the response
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            s_axi_awready_out <= 1'b0;
        end else begin
            s_axi_awready_out <= !aw_have_next && !bvalid_next && (wr_state_reg != BAR_WS_COMMIT);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            s_axi_wready_out <= 1'b0;
        end else begin
            s_axi_wready_out <= !w_have_next && !bvalid_next && (wr_state_reg != BAR_WS_COMMIT);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            aw_addr_reg <= {`BAR_AXI_ADDR_W{1'b0}};
        end else if (aw_take) begin
            aw_addr_reg <= s_axi_awaddr_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            w_data_reg <= 32'h00000000;
        end else if (w_take) begin
            w_data_reg <= s_axi_wdata_in;
        end
    end

    // strobes are kept with the data, since the commit may come cycles after the beat
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            w_strb_reg <= 4'h0;
        end else if (w_take) begin
            w_strb_reg <= s_axi_wstrb_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            s_axi_bresp_out <= `BAR_RESP_OKAY;
        end else if (wr_state_reg == BAR_WS_COMMIT) begin
            s_axi_bresp_out <= (wr_sel == BAR_SEL_NONE) ? `BAR_RESP_SLVERR : `BAR_RESP_OKAY;
        end
    end

    always_comb begin
        range_low_next = range_low_reg;
        range_high_next = range_high_reg;
        if (wr_state_reg == BAR_WS_COMMIT) begin
            if (wr_sel == BAR_SEL_LOW) begin
                range_low_next = merge_write(range_low_reg, w_data_reg, w_strb_reg);
            end
            if (wr_sel == BAR_SEL_HIGH) begin
                range_high_next = merge_write(range_high_reg, w_data_reg, w_strb_reg);
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            range_low_reg <= `BAR_RANGE_RESET;
        end else begin
            range_low_reg <= range_low_next;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            range_high_reg <= `BAR_RANGE_RESET;
        end else begin
            range_high_reg <= range_high_next;
        end
    end

    // flags channels whose code moved, so the front end can let its input settle
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            range_changed_out <= 8'h00;
        end else begin
            for (int i = 0; i < 4; i++) begin
                range_changed_out[i] <= range_low_next[2*i +: 2] != range_low_reg[2*i +: 2];
                range_changed_out[i+4] <= range_high_next[2*i +: 2] != range_high_reg[2*i +: 2];
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            s_axi_rvalid_out <= 1'b0;
        end else begin
            s_axi_rvalid_out <= rvalid_next;
        end
    end

    // one read at a time: the address channel stays shut while a response is pending
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            s_axi_arready_out <= 1'b0;
        end else begin
            s_axi_arready_out <= !rvalid_next;
        end
    end

    always_comb begin
        rvalid_next = s_axi_rvalid_out;
        if (ar_take) begin
            rvalid_next = 1'b1;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= `BAR_RESP_OKAY;
        end else if (ar_take) begin
            if (rd_sel == BAR_SEL_LOW) begin
                s_axi_rdata_out <= read_word(`BAR_RANGE_LOW_IDX, range_low_reg);
                s_axi_rresp_out <= `BAR_RESP_OKAY;
            end else if (rd_sel == BAR_SEL_HIGH) begin
                s_axi_rdata_out <= read_word(`BAR_RANGE_HIGH_IDX, range_high_reg);
                s_axi_rresp_out <= `BAR_RESP_OKAY;
            end else begin
                s_axi_rdata_out <= 32'h00000000;
                s_axi_rresp_out <= `BAR_RESP_SLVERR;
            end
        end
    end

    // channel codes come straight from the register flops
    assign bank_a_channel_0_range_out = range_low_reg[`BAR_CH0_LSB +: 2];
    assign bank_a_channel_1_range_out = range_low_reg[`BAR_CH1_LSB +: 2];
    assign bank_a_channel_2_range_out = range_low_reg[`BAR_CH2_LSB +: 2];
    assign bank_a_channel_3_range_out = range_low_reg[`BAR_CH3_LSB +: 2];
    assign bank_a_channel_4_range_out = range_high_reg[`BAR_CH0_LSB +: 2];
    assign bank_a_channel_5_range_out = range_high_reg[`BAR_CH1_LSB +: 2];
    assign bank_a_channel_6_range_out = range_high_reg[`BAR_CH2_LSB +: 2];
    assign bank_a_channel_7_range_out = range_high_reg[`BAR_CH3_LSB +: 2];

    assign chan_flat = {range_high_reg[7:0], range_low_reg[7:0]};

    // decoded selects lag the codes by one cycle
    for (genvar g = 0; g < 8; g++) begin : g_dec
        bar_range_decode u_dec (
            .sys_clk_in(sys_clk_in),
            .reset_n_in(reset_n_in),
            .code_in(chan_flat[2*g +: 2]),
            .sel_10v_out(range_10v_sel_out[g]),
            .sel_5v_out(range_5v_sel_out[g]),
            .sel_2p5v_out(range_2p5v_sel_out[g])
        );
    end

endmodule // bar_range_regs

// *** verification/bar_range_regs_chk.sv ***
`timescale 1ns/100ps
module bar_range_regs_chk (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0] bank_a_channel_0_range_out,
    input wire logic [1:0] bank_a_channel_3_range_out,
    input wire logic [1:0] bank_a_channel_4_range_out,
    input wire logic [1:0] bank_a_channel_5_range_out,
    input wire logic [1:0] bank_a_channel_7_range_out,
    input wire logic [7:0] range_10v_sel_out,
    input wire logic [7:0] range_5v_sel_out,
    input wire logic [7:0] range_2p5v_sel_out,
    input wire logic [7:0] range_changed_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_wr_take(a);
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out && s_axi_wstrb_in[0]
            && s_axi_awaddr_in == a;
    endsequence
    sequence s_rd_take(a);
        s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == a;
    endsequence
    property p_wr_low;
        s_wr_take(8'h10) |-> ##2 bank_a_channel_0_range_out == $past(s_axi_wdata_in[1:0], 2);
    endproperty
    property p_wr_high;
        s_wr_take(8'h14) |-> ##2 bank_a_channel_4_range_out == $past(s_axi_wdata_in[1:0], 2);
    endproperty
    property p_rd_low;
        s_rd_take(8'h10) |=> s_axi_rdata_out[31:9] == {16'h0000, 7'h04};
    endproperty
    property p_rd_high;
        s_rd_take(8'h14) |=> s_axi_rdata_out[31:9] == {16'h0000, 7'h05};
    endproperty
    // a code may only move while a write is in flight, which keeps awready low
    property p_hold;
        $past(s_axi_awready_out) && s_axi_awready_out |-> $stable(bank_a_channel_4_range_out);
    endproperty
    property p_sel3;
        range_5v_sel_out[3] == ($past(bank_a_channel_3_range_out) == 2'b10);
    endproperty
    property p_sel7;
        range_2p5v_sel_out[7] == ($past(bank_a_channel_7_range_out) == 2'b01);
    endproperty
    property p_sel5;
        range_10v_sel_out[5] == ($past(bank_a_channel_5_range_out) inside {2'b00, 2'b11});
    endproperty
    a_wr_low: assert property (p_wr_low) else $error("channel 0 code not written");
    a_wr_high: assert property (p_wr_high) else $error("channel 4 code not written");
    a_rd_low: assert property (p_rd_low) else $error("low word address field wrong");
    a_rd_high: assert property (p_rd_high) else $error("high word address field wrong");
    a_hold: assert property (p_hold) else $error("channel 4 code moved without a write");
    a_sel3: assert property (p_sel3) else $error("channel 3 5v select wrong");
    a_sel7: assert property (p_sel7) else $error("channel 7 2p5v select wrong");
    a_sel5: assert property (p_sel5) else $error("channel 5 10v select wrong");
    // a change pulse stands in the first cycle that shows the new code, and only then
    property p_chg;
        range_changed_out[0] == (bank_a_channel_0_range_out != $past(bank_a_channel_0_range_out))
            && range_changed_out[4] == (bank_a_channel_4_range_out != $past(bank_a_channel_4_range_out));
    endproperty
    a_chg: assert property (p_chg) else $error("change pulse wrong for channel 0 or 4");
endmodule // bar_range_regs_chk

bind bar_range_regs bar_range_regs_chk u_bar_range_regs_chk (.*);

// *** verification/bar_range_regs_tb.sv ***
`timescale 1ns/100ps
module bar_range_regs_tb;
    logic sys_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
    logic [2:0] s_axi_awprot_in = 3'h0, s_axi_arprot_in = 3'h0;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic [1:0] bank_a_channel_0_range_out, bank_a_channel_1_range_out, bank_a_channel_2_range_out;
    logic [1:0] bank_a_channel_3_range_out, bank_a_channel_4_range_out, bank_a_channel_5_range_out;
    logic [1:0] bank_a_channel_6_range_out, bank_a_channel_7_range_out;
    logic [7:0] range_10v_sel_out, range_5v_sel_out, range_2p5v_sel_out, range_changed_out;
    logic [15:0] codes;
    logic [31:0] rdv;
    logic [1:0] resp;
    logic [7:0] chg_last = 8'h00;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;

    bar_range_regs u_bar_range_regs (.*);

    assign codes = {bank_a_channel_7_range_out, bank_a_channel_6_range_out, bank_a_channel_5_range_out,
        bank_a_channel_4_range_out, bank_a_channel_3_range_out, bank_a_channel_2_range_out,
        bank_a_channel_1_range_out, bank_a_channel_0_range_out};

    always #50 sys_clk_in = ~sys_clk_in;

    // the change pulse lasts one cycle; catch it mid-cycle, where it is settled
    always @(negedge sys_clk_in) begin
        if (range_changed_out != 8'h00) begin
            chg_last <= range_changed_out;
        end
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // both channels are offered together; each is dropped on its own handshake edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge sys_clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_wstrb_in <= s;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        while (aw || w) begin
            @(posedge sys_clk_in);
            aw = aw && !s_axi_awready_out;
            w = w && !s_axi_wready_out;
            s_axi_awvalid_in <= aw;
            s_axi_wvalid_in <= w;
        end
        while (!s_axi_bvalid_out) @(posedge sys_clk_in);
        r = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do @(posedge sys_clk_in); while (!s_axi_arready_out);
        s_axi_arvalid_in <= 1'b0;
        do @(posedge sys_clk_in); while (!s_axi_rvalid_out);
        d = s_axi_rdata_out;
        r = s_axi_rresp_out;
        s_axi_rready_in <= 1'b0;
    endtask

    task automatic t_reset;
        chk("codes", 32'h0000FFFF, {16'h0, codes});
        rd(8'h10, rdv, resp);
        chk("low word", 32'h000008FF, rdv);
        chk("low resp", 32'h0, {30'h0, resp});
        rd(8'h14, rdv, resp);
        chk("high word", 32'h00000AFF, rdv);
        chk("high resp", 32'h0, {30'h0, resp});
        chk("no change pulse", 32'h0, {24'h0, range_changed_out});
        $display("reset values done");
    endtask

    // every code in every field; the high word carries the inverse so neighbours differ
    task automatic t_codes;
        logic [1:0] c;
        logic [7:0] b;
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            b = {4{c}};
            wr(8'h10, 32'hFFFFFE00 | {24'h0, b}, 4'hF, resp);
            chk("low wr resp", 32'h0, {30'h0, resp});
            wr(8'h14, 32'hFFFFFE00 | {24'h0, ~b}, 4'hF, resp);
            chk("high wr resp", 32'h0, {30'h0, resp});
            chk("changed", {24'h0, (i == 0) ? 8'h0F : 8'hF0}, {24'h0, chg_last});
            rd(8'h10, rdv, resp);
            chk("low word", {16'h0, 7'h04, 1'b0, b}, rdv);
            rd(8'h14, rdv, resp);
            chk("high word", {16'h0, 7'h05, 1'b0, ~b}, rdv);
            chk("codes", {16'h0, ~b, b}, {16'h0, codes});
            chk("sel 10v", {24'h0, {8{c[0] == c[1]}}}, {24'h0, range_10v_sel_out});
            chk("sel 5v", {24'h0, {4{c == 2'b01}}, {4{c == 2'b10}}}, {24'h0, range_5v_sel_out});
            chk("sel 2p5v", {24'h0, {4{c == 2'b10}}, {4{c == 2'b01}}}, {24'h0, range_2p5v_sel_out});
        end
        $display("range codes done");
    endtask

    task automatic t_rsvd;
        wr(8'h10, 32'h00000100, 4'h1, resp);
        rd(8'h10, rdv, resp);
        chk("bit 8 kept", 32'h00000800, rdv);
        wr(8'h10, 32'h000001E4, 4'h3, resp);
        rd(8'h10, rdv, resp);
        chk("bit 8 set", 32'h000009E4, rdv);
        $display("reserved bit done");
    endtask

    task automatic t_unmapped;
        wr(8'h18, 32'h00000000, 4'hF, resp);
        chk("bad write resp", 32'h2, {30'h0, resp});
        rd(8'h10, rdv, resp);
        chk("low untouched", 32'h000009E4, rdv);
        rd(8'h0C, rdv, resp);
        chk("bad read data", 32'h0, rdv);
        chk("bad read resp", 32'h2, {30'h0, resp});
        $display("unmapped done");
    endtask

    // a reset in mid-run brings a written word and its reserved bit back to reset values
    task automatic t_midreset;
        wr(8'h14, 32'h00000155, 4'h3, resp);
        reset_n_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        chk("codes after reset", 32'h0000FFFF, {16'h0, codes});
        rd(8'h14, rdv, resp);
        chk("high after reset", 32'h00000AFF, rdv);
        rd(8'h10, rdv, resp);
        chk("low after reset", 32'h000008FF, rdv);
        $display("mid-run reset done");
    endtask

    initial begin
        repeat (3) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        t_reset();
        t_codes();
        t_rsvd();
        t_unmapped();
        t_midreset();
        give_verdict();
    end

    // the whole run needs well under two hundred cycles
    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors++;
            give_verdict();
        end
    end
endmodule // bar_range_regs_tb
